// ---- rtl/dcsp_pkg.sv ----
// constants, types and control-byte layout of the daisy-chain serial control port
// assumes: a two-channel device, 8-bit registers and 16-bit indirect table words
package dcsp_pkg;
  localparam int N_CHAN = 2;
  localparam int ADDR_W = 7;
  localparam int RAM_W = 16;
  localparam int REG_DEPTH = 128;
  localparam int BCAST_BIT = 7;
  localparam int DIR_BIT = 6;
  localparam int SPACE_BIT = 5;
  // bits already received when channel_identifier bit 0 arrives
  localparam logic [2:0] CID_START_CNT = 3'h4;
  localparam logic [2:0] LAST_BIT_CNT = 3'h7;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic SPACE_RAM = 1'b0;

  typedef enum logic [1:0] {PH_CTRL, PH_ADDR, PH_DATA1, PH_DATA2} dcsp_phase_t;

  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [RAM_W-1:0] data;
  } dcsp_req_t;
endpackage : dcsp_pkg

// ---- rtl/dcsp_ram_if.sv ----
// table request and answer path between the serial port and one channel
// assumes: spi side on the serial clock, chan side on the core clock
interface dcsp_ram_if
  import dcsp_pkg::*;
  ();
  logic req_tgl;
  dcsp_req_t req;
  logic done_tgl;
  logic [RAM_W-1:0] rdata;

  modport spi (output req_tgl, output req, input done_tgl, input rdata);
  modport chan (input req_tgl, input req, output done_tgl, output rdata);
endinterface : dcsp_ram_if

// ---- rtl/dcsp_chan.sv ----
// one channel's table address and data buffers and its pending request
// assumes: requests arrive as a toggle with a word held stable behind it
module dcsp_chan
  import dcsp_pkg::*;
  (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_service_slot,
  input wire logic [RAM_W-1:0] i_ram_rdata,
  dcsp_ram_if.chan ram,
  output logic o_ram_we,
  output logic o_ram_re,
  output logic [ADDR_W-1:0] o_ram_addr,
  output logic [RAM_W-1:0] o_ram_wdata,
  output logic o_pending,
  output logic o_done
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic seen;
    dcsp_req_t req;
    logic pending;
    logic we;
    logic re;
    logic [ADDR_W-1:0] addr;
    logic [RAM_W-1:0] wdata;
    logic done;
    logic done_tgl;
    logic [RAM_W-1:0] rdata;
  } dcsp_chan_st_t;

  dcsp_chan_st_t q;
  dcsp_chan_st_t d;
  logic busy;
  logic start;

  assign busy = q.we | q.re;
  assign start = i_service_slot & q.pending & ~busy;

  always_comb
  begin
    d = q;
    d.we = 1'b0;
    d.re = 1'b0;
    d.done = 1'b0;
    d.sync1 = ram.req_tgl;
    d.sync2 = q.sync1;
    if (start)
    begin
      d.addr = q.req.addr;
      d.wdata = q.req.data;
      d.we = q.req.wr;
      d.re = ~q.req.wr;
    end
    if (busy)
    begin
      d.pending = 1'b0;
      d.done = 1'b1;
      if (q.re)
      begin
        d.rdata = i_ram_rdata;
        d.done_tgl = ~q.done_tgl;
      end
    end
    // new request waits while one is in service, so set and clear never share a cycle
    if (!start && !busy && (q.sync2 != q.seen))
    begin
      d.seen = q.sync2;
      d.req = ram.req;
      d.pending = 1'b1;
    end
    if (!i_rst_n)
    begin
      d = '0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    q <= d;
  end

  assign ram.done_tgl = q.done_tgl;
  assign ram.rdata = q.rdata;
  assign o_ram_we = q.we;
  assign o_ram_re = q.re;
  assign o_ram_addr = q.addr;
  assign o_ram_wdata = q.wdata;
  assign o_pending = q.pending;
  assign o_done = q.done;

  a_pending_clear_done: assert property (
    @(posedge i_clk) disable iff (!i_rst_n) $fell(q.pending) |-> q.done)
    else $error("pending cleared without a completion event");

  a_slot_service: assert property (
    @(posedge i_clk) disable iff (!i_rst_n) start |=> (q.we ^ q.re) ##1 (q.done && !q.we && !q.re))
    else $error("slot did not service the pending request");
endmodule : dcsp_chan

// ---- rtl/dcsp_port.sv ----
// serial control port: control byte decode, daisy-chain pass-through,
// per-channel 8-bit registers and 16-bit table request hand-off
// assumes: the serial clock is a clock port, i_cs_n and i_sdi are on it,
// the table servicing logic and the service slots are on i_clk
//////////////////////////////////////////////////////////////////////////////

// How it works
// - Broadcast bit 7 reaches all devices; controller uses it for writes only.
// - Control bit 6: zero writes, one reads.
// - Control bit 5: zero selects table words, one selects 8-bit registers.
// - Control bits 3:0 hold channel_identifier, sent least significant bit first.
// - Each channel forwards channel_identifier minus one; device passes minus two.
// - Only the channel seeing identifier zero acts; only it drives serial out.
// - Broadcast forwards identifier unchanged; every channel applies the write.
// - Broadcast, direction and space bits pass down the chain unchanged.
// - 8-bit controller: three bytes, select high after data ends the access.
// - Serial input is ignored while read data shifts out.
// - 16-bit controller: select held low after data means eight more clocks.
// - 16-bit register write discards the trailing eight bits.
// - 16-bit register read sends the register byte twice.
// - Register read loads the shift register when the address byte ends.
// - Register write commits only when the data byte is complete.
// - Table accesses always carry four bytes: control, address, two data.
// - Table read returns the channel data buffer: one-deep pipeline.
// - Table read posts its address and a pending read after the data phase.
// - Table write posts address and data and a pending write.
// - Pending status per channel; requests served at dedicated slots.
// - Each channel raises an event once its request is served.
// - Buffers and pending status kept per channel; both may be outstanding.
// - Select change at a bit count not a multiple of eight restarts the port.
// - Control byte then address byte, seven low bits used; MSB first.
// - Up to eight devices chain through serial_passthrough_out.
module dcsp_port
  import dcsp_pkg::*;
  (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe_n,
  output logic o_serial_passthrough_out,
  input wire logic i_service_slot,
  input wire logic [N_CHAN-1:0][RAM_W-1:0] i_ram_rdata,
  output logic [N_CHAN-1:0] o_ram_we,
  output logic [N_CHAN-1:0] o_ram_re,
  output logic [N_CHAN-1:0][ADDR_W-1:0] o_ram_addr,
  output logic [N_CHAN-1:0][RAM_W-1:0] o_ram_wdata,
  output logic [N_CHAN-1:0] o_table_access_pending,
  output logic [N_CHAN-1:0] o_ram_access_done
);

  function automatic logic [3:0] cid_of(input logic [7:0] ctrl);
    // identifier bit 0 sits in control bit 3
    cid_of = {ctrl[0], ctrl[1], ctrl[2], ctrl[3]};
  endfunction : cid_of

  function automatic logic [N_CHAN-1:0] chan_sel(input logic [7:0] ctrl);
    logic [3:0] channel_identifier;
    channel_identifier = cid_of(ctrl);
    // identifier zero selects channel 0, identifier one channel 1; broadcast selects both channels
    chan_sel = {ctrl[BCAST_BIT] | (channel_identifier == 4'h1), ctrl[BCAST_BIT] | (channel_identifier == 4'h0)};
  endfunction : chan_sel

  //////////////////////////////////////////////////////////////////////////////
  // serial clock domain state

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    dcsp_phase_t phase;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic [7:0] ctrl;
    logic bc_now;
    logic borrow;
    logic [N_CHAN-1:0] sel;
    logic [ADDR_W-1:0] addr;
    logic [7:0] hi;
    logic [7:0] tx;
    logic drive;
    logic [N_CHAN-1:0][RAM_W-1:0] rd_buf;
    logic [N_CHAN-1:0] dsync1;
    logic [N_CHAN-1:0] dsync2;
    logic [N_CHAN-1:0] dseen;
    logic [N_CHAN-1:0] req_tgl;
    dcsp_req_t [N_CHAN-1:0] req;
  } dcsp_spi_st_t;

  dcsp_spi_st_t q;
  dcsp_spi_st_t d;
  logic cs_gap_q;
  logic [7:0] regs_q [N_CHAN][REG_DEPTH];
  logic [N_CHAN-1:0] reg_we;
  logic [ADDR_W-1:0] reg_waddr;
  logic [7:0] reg_wdata;
  logic [N_CHAN-1:0] done_tgl_w;
  logic [N_CHAN-1:0][RAM_W-1:0] rdata_w;
  logic [7:0] byte_in;
  logic is_read;
  logic is_reg;
  logic [7:0] reg_rd;

  assign byte_in = {q.sh[6:0], i_sdi};
  assign is_read = (q.ctrl[DIR_BIT] != DIR_WRITE);
  assign is_reg = (q.ctrl[SPACE_BIT] != SPACE_RAM);
  assign reg_rd = regs_q[q.sel[1]][byte_in[ADDR_W-1:0]];

  // remembers that select went high since the last serial clock edge
  always_ff @(posedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      cs_gap_q <= 1'b1;
    end
    else
    begin
      cs_gap_q <= 1'b0;
    end
  end

  always_comb
  begin
    dcsp_phase_t phase_v;
    logic [2:0] cnt_v;
    phase_v = q.phase;
    cnt_v = q.cnt;
    d = q;
    reg_we = '0;
    reg_waddr = q.addr;
    reg_wdata = byte_in;
    d.rst_s1 = i_rst_n;
    d.rst_s2 = q.rst_s1;
    d.dsync1 = done_tgl_w;
    d.dsync2 = q.dsync1;
    // latest answered read word becomes the channel data buffer
    for (int c = 0; c < N_CHAN; c++)
    begin
      if (q.dsync2[c] != q.dseen[c])
      begin
        d.dseen[c] = q.dsync2[c];
        d.rd_buf[c] = rdata_w[c];
      end
    end
    if (!i_cs_n)
    begin
      // misaligned select restarts with this bit as control bit 7
      if (cs_gap_q && (q.cnt != 3'h0))
      begin
        phase_v = PH_CTRL;
        cnt_v = 3'h0;
        d.drive = 1'b0;
      end
      // select high after a register data byte ends the access
      if (cs_gap_q && (phase_v == PH_DATA2) && is_reg)
      begin
        phase_v = PH_CTRL;
        d.drive = 1'b0;
      end
      d.phase = phase_v;
      d.cnt = cnt_v + 3'h1;
      d.sh = byte_in;
      if (q.drive)
      begin
        d.tx = {q.tx[6:0], 1'b0};
      end
      // first bit of the control byte is broadcast
      if ((phase_v == PH_CTRL) && (cnt_v == 3'h0))
      begin
        d.bc_now = i_sdi;
      end
      // serial subtract of two, starting at identifier bit 1
      if ((phase_v == PH_CTRL) && (cnt_v == CID_START_CNT))
      begin
        d.borrow = 1'b1;
      end
      else if ((phase_v == PH_CTRL) && (cnt_v > CID_START_CNT))
      begin
        d.borrow = q.borrow & ~i_sdi;
      end
      if (cnt_v == LAST_BIT_CNT)
      begin
        unique case (phase_v)
          PH_CTRL:
          begin
            d.ctrl = byte_in;
            d.sel = chan_sel(byte_in);
            d.phase = PH_ADDR;
          end
          PH_ADDR:
          begin
            // only seven address bits are kept
            d.addr = byte_in[ADDR_W-1:0];
            d.phase = PH_DATA1;
            // selected channel loads its read data, never on broadcast
            if (is_read && !q.ctrl[BCAST_BIT] && (q.sel != '0))
            begin
              d.drive = 1'b1;
              d.tx = is_reg ? reg_rd : q.rd_buf[q.sel[1]][RAM_W-1:8];
              d.hi = is_reg ? reg_rd : q.rd_buf[q.sel[1]][7:0];
            end
          end
          PH_DATA1:
          begin
            d.phase = PH_DATA2;
            if (is_read)
            begin
              // second byte repeats the register, or is the low table byte
              d.tx = q.hi;
            end
            else
            begin
              // the data byte is only taken on writes
              d.hi = byte_in;
            end
            // register write commits on a complete data byte
            if (is_reg && !is_read)
            begin
              reg_we = q.sel;
            end
          end
          PH_DATA2:
          begin
            d.phase = PH_CTRL;
            d.drive = 1'b0;
            // table access posts to the target channel
            if (!is_reg && !(is_read && q.ctrl[BCAST_BIT]))
            begin
              for (int c = 0; c < N_CHAN; c++)
              begin
                if (q.sel[c])
                begin
                  d.req[c].wr = ~is_read;
                  d.req[c].addr = q.addr;
                  d.req[c].data = {q.hi, byte_in};
                  d.req_tgl[c] = ~q.req_tgl[c];
                end
              end
            end
          end
        endcase
      end
    end
    if (!q.rst_s2)
    begin
      d = '0;
      d.rst_s1 = i_rst_n;
      d.rst_s2 = q.rst_s1;
      reg_we = '0;
    end
  end

  always_ff @(posedge i_sclk)
  begin
    q <= d;
  end

  always_ff @(posedge i_sclk)
  begin
    for (int c = 0; c < N_CHAN; c++)
    begin
      if (reg_we[c])
      begin
        regs_q[c][reg_waddr] <= reg_wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pins

  assign o_sdo = q.tx[7];
  // driver released whenever select is high, and on the first bit of a new access
  assign o_sdo_oe_n = i_cs_n | ~q.drive
                      | (cs_gap_q & ((q.cnt != 3'h0) | ((q.phase == PH_DATA2) & is_reg)));
  // only identifier bits 1..3 may change; a restarting bit passes untouched
  assign o_serial_passthrough_out = i_sdi ^ ((q.phase == PH_CTRL) && (q.cnt > CID_START_CNT)
                                             && !q.bc_now && q.borrow && !cs_gap_q);

  //////////////////////////////////////////////////////////////////////////////
  // channels on the core clock

  for (genvar c = 0; c < N_CHAN; c++)
  begin : g_chan
    dcsp_ram_if u_if ();
    assign u_if.req_tgl = q.req_tgl[c];
    assign u_if.req = q.req[c];
    assign done_tgl_w[c] = u_if.done_tgl;
    assign rdata_w[c] = u_if.rdata;

    dcsp_chan u_chan (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_service_slot(i_service_slot),
      .i_ram_rdata(i_ram_rdata[c]),
      .ram(u_if.chan),
      .o_ram_we(o_ram_we[c]),
      .o_ram_re(o_ram_re[c]),
      .o_ram_addr(o_ram_addr[c]),
      .o_ram_wdata(o_ram_wdata[c]),
      .o_pending(o_table_access_pending[c]),
      .o_done(o_ram_access_done[c])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  a_soft_reset_idle: assert property (
    @(posedge i_sclk) disable iff (!q.rst_s2)
    (!i_cs_n && cs_gap_q && q.cnt != 3'h0) |=> (q.phase == PH_CTRL && q.cnt == 3'h1))
    else $error("misaligned select did not restart the port");

  a_cid_zero_sel: assert property (
    @(posedge i_sclk) disable iff (!q.rst_s2)
    (!i_cs_n && !cs_gap_q && q.phase == PH_CTRL && q.cnt == LAST_BIT_CNT && !q.bc_now)
    |=> (q.sel[0] == (cid_of(q.ctrl) == 4'h0)) && (q.sel[1] == (cid_of(q.ctrl) == 4'h1)))
    else $error("channel select does not match identifier");

  a_bcast_all_sel: assert property (
    @(posedge i_sclk) disable iff (!q.rst_s2)
    (!i_cs_n && !cs_gap_q && q.phase == PH_CTRL && q.cnt == LAST_BIT_CNT && q.bc_now)
    |=> q.sel == 2'h3)
    else $error("broadcast did not select both channels");

  a_passthru_field: assert property (
    @(posedge i_sclk) disable iff (!q.rst_s2)
    (o_serial_passthrough_out != i_sdi)
    |-> (q.phase == PH_CTRL && q.cnt > CID_START_CNT && !q.bc_now && !cs_gap_q))
    else $error("pass-through altered a bit outside the identifier");

  a_read_drive_load: assert property (
    @(posedge i_sclk) disable iff (!q.rst_s2)
    (!i_cs_n && !cs_gap_q && q.phase == PH_ADDR && q.cnt == LAST_BIT_CNT && is_read
     && !q.ctrl[BCAST_BIT] && q.sel != '0) |=> (q.drive && q.phase == PH_DATA1))
    else $error("read data not loaded after the address byte");

  a_write_commit_time: assert property (
    @(posedge i_sclk) disable iff (!q.rst_s2)
    (reg_we != '0) |-> (q.phase == PH_DATA1 && q.cnt == LAST_BIT_CNT && is_reg && !is_read && !i_cs_n))
    else $error("register written outside data byte completion");

  a_reg_read_repeat: assert property (
    @(posedge i_sclk) disable iff (!q.rst_s2)
    (!i_cs_n && !cs_gap_q && q.phase == PH_DATA1 && q.cnt == LAST_BIT_CNT && is_reg && is_read)
    |=> (q.tx == $past(q.hi)))
    else $error("register byte not repeated in second half");

  a_ram_req_post: assert property (
    @(posedge i_sclk) disable iff (!q.rst_s2)
    (!i_cs_n && !cs_gap_q && q.phase == PH_DATA2 && q.cnt == LAST_BIT_CNT && !is_reg && q.sel[0]
     && !(is_read && q.ctrl[BCAST_BIT])) |=> (q.req_tgl[0] != $past(q.req_tgl[0])))
    else $error("table request not posted to channel 0");
endmodule : dcsp_port

// ---- dv/dcsp_spi_ctrl.sv ----
// serial controller model for the control port: frames of up to 32 bits on a 48 ns link clock
// assumes: the bench resolves the pulled-down serial output and feeds it back on i_sdo
module dcsp_spi_ctrl
  (
  input wire logic i_sdo,
  input wire logic i_pt,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdi
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam time HALF = 24ns;
  logic [31:0] rx;
  logic [31:0] pt;
  event frame_done;

  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
  end

  // clocks with select high; released data line toggles so a stale level never shows
  task automatic idle(input int n);
    repeat (n)
    begin
      #HALF o_sclk = 1'b1;
      #(HALF / 2) o_sdi = ~o_sdi;
      #(HALF / 2) o_sclk = 1'b0;
    end
  endtask : idle

  // msb first, select may rise between bytes
  task automatic xfer(input logic [31:0] tx, input int nbits, input bit split);
    for (int i = 0; i < nbits; i++)
    begin
      if (split && i > 0 && i % 8 == 0)
      begin
        o_cs_n = 1'b1;
        idle(1);
      end
      o_cs_n = 1'b0;
      o_sdi = tx[31-i];
      #HALF o_sclk = 1'b1;
      rx[31-i] = i_sdo;
      pt[31-i] = i_pt;
      #HALF o_sclk = 1'b0;
    end
    o_cs_n = 1'b1;
    idle(2);
    -> frame_done;
  endtask : xfer
endmodule : dcsp_spi_ctrl

// ---- dv/test_daisy_chain_spi_control_port.sv ----
// self-checking bench for the serial control port and its table request path
// assumes: the controller model drives the link; the bench plays the table and slots
module test_daisy_chain_spi_control_port
  import dcsp_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] data; logic [31:0] mask;} dcsp_note_t;
  typedef struct {logic we; logic [ADDR_W-1:0] addr; logic [RAM_W-1:0] data;} dcsp_ram_note_t;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_service_slot = 1'b0;
  logic [N_CHAN-1:0][RAM_W-1:0] i_ram_rdata = '0;
  logic sclk, cs_n, sdi, o_sdo, o_sdo_oe_n, sdo_wire, pt;
  logic [N_CHAN-1:0] o_ram_we, o_ram_re, o_table_access_pending, o_ram_access_done;
  logic [N_CHAN-1:0][ADDR_W-1:0] o_ram_addr;
  logic [N_CHAN-1:0][RAM_W-1:0] o_ram_wdata;
  logic [1:0] done_seen = 2'b00;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  dcsp_note_t exp_q[$];
  dcsp_ram_note_t ram_q[2][$];
  logic [6:0] a;
  logic [7:0] d;
  logic [6:0] ta[2];
  logic [15:0] td[2];
  logic [15:0] last[2];
  logic [15:0] rd;

  always #5 i_clk = ~i_clk;
  // pull-down on the serial output
  assign sdo_wire = o_sdo_oe_n ? 1'b0 : o_sdo;

  dcsp_port i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_sdi(sdi),
    .o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n), .o_serial_passthrough_out(pt),
    .i_service_slot(i_service_slot), .i_ram_rdata(i_ram_rdata), .o_ram_we(o_ram_we),
    .o_ram_re(o_ram_re), .o_ram_addr(o_ram_addr), .o_ram_wdata(o_ram_wdata),
    .o_table_access_pending(o_table_access_pending), .o_ram_access_done(o_ram_access_done));
  dcsp_spi_ctrl i_ctrl (.i_sdo(sdo_wire), .i_pt(pt), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi));

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // identifier lsb first, bit 4 zero
  function automatic logic [7:0] ctl(input logic bc, input logic rdn, input logic rg, input logic [3:0] id);
    return {bc, rdn, rg, 1'b0, id[0], id[1], id[2], id[3]};
  endfunction : ctl

  task automatic frame(input logic [31:0] tx, input int nbits, input bit split, input logic [31:0] ex,
    input logic [31:0] mk);
    logic [3:0] id;
    logic [7:0] c;
    logic [31:0] m;
    c = tx[31:24];
    id = {c[0], c[1], c[2], c[3]} - 4'h2;
    m = ~(32'hffffffff >> nbits);
    exp_q.push_back('{ex, mk});
    i_ctrl.xfer(tx, nbits, split);
    if (c[7] !== 1'b1)
      c[3:0] = {id[0], id[1], id[2], id[3]};
    check(i_ctrl.pt & m, {c, tx[23:0]} & m);
  endtask : frame

  task automatic wait_pending(input logic [1:0] m);
    for (int k = 0; k < 20 && o_table_access_pending !== m; k++)
      @(negedge i_clk);
    check(32'(o_table_access_pending), 32'(m));
  endtask : wait_pending

  task automatic serve(input logic [1:0] m);
    done_seen = 2'b00;
    @(posedge i_clk);
    i_service_slot <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_service_slot <= 1'b0;
    repeat (6) @(posedge i_clk);
    check(32'(done_seen), 32'(m));
    check(32'(o_table_access_pending), 32'h0);
  endtask : serve

  //////////////////////////////////////////////////////////////////////////////
  always @(negedge i_clk)
    done_seen <= done_seen | o_ram_access_done;

  initial
  begin
    forever
    begin
      @(i_ctrl.frame_done);
      if (exp_q.size() > 0)
        check(i_ctrl.rx & exp_q[0].mask, exp_q[0].data & exp_q[0].mask);
      if (exp_q.size() > 0)
        void'(exp_q.pop_front());
    end
  end

  always @(negedge i_clk)
  begin
    for (int c = 0; c < 2; c++)
    begin
      if (o_ram_we[c] === 1'b1 || o_ram_re[c] === 1'b1)
      begin
        if (ram_q[c].size() == 0)
          check(32'(o_ram_we[c]), 32'h2);
        else
        begin
          check({8'h0, o_ram_we[c], o_ram_addr[c], o_ram_we[c] ? o_ram_wdata[c] : 16'h0},
            {8'h0, ram_q[c][0].we, ram_q[c][0].addr, ram_q[c][0].we ? ram_q[c][0].data : 16'h0});
          void'(ram_q[c].pop_front());
        end
      end
    end
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial
  begin
    void'($urandom(4));
    // serial side needs link clock edges while reset is low
    fork
      begin
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
      end
    join_none
    i_ctrl.idle(10);
    for (int c = 0; c < 2; c++)
    begin
      a = 7'($urandom);
      d = 8'($urandom);
      frame({ctl(0, 0, 1, c), 1'b1, a, d, 8'h00}, 24, 1, 0, 0);
      frame({ctl(0, 1, 1, c), 1'b0, a, 8'($urandom), 8'h00}, 24, 1, {16'h0, d, 8'h0}, 32'h0000ff00);
    end
    $display("test done: 8-bit register access");
    d = 8'($urandom);
    frame({ctl(0, 0, 1, 0), 1'b0, a, d, ~d}, 32, 0, 0, 0);
    frame({ctl(0, 1, 1, 0), 1'b0, a, 16'($urandom)}, 32, 0, {16'h0, d, d}, 32'h0000ffff);
    $display("test done: 16-bit register access");
    frame({ctl(0, 0, 1, 3), 1'b0, a, ~d, 8'h00}, 24, 1, 0, 0);
    frame({ctl(0, 1, 1, 3), 1'b0, a, 8'($urandom), 8'h00}, 24, 1, 0, 32'h0000ff00);
    frame({ctl(0, 1, 1, 0), 1'b0, a, 8'($urandom), 8'h00}, 24, 1, {16'h0, d, 8'h0}, 32'h0000ff00);
    $display("test done: other identifier");
    d = 8'($urandom);
    frame({ctl(1, 0, 1, 5), 1'b0, a, d, 8'h00}, 24, 1, 0, 32'hffffff00);
    for (int c = 0; c < 2; c++)
      frame({ctl(0, 1, 1, c), 1'b0, a, 8'($urandom), 8'h00}, 24, 1, {16'h0, d, 8'h0}, 32'h0000ff00);
    $display("test done: broadcast write");
    frame({ctl(0, 0, 1, 0), 24'hffffff}, 5, 0, 0, 0);
    d = 8'($urandom);
    frame({ctl(0, 0, 1, 0), 1'b0, a, d, 8'h00}, 24, 1, 0, 0);
    frame({ctl(0, 1, 1, 0), 1'b0, a, 8'($urandom), 8'h00}, 24, 1, {16'h0, d, 8'h0}, 32'h0000ff00);
    $display("test done: soft restart");
    for (int c = 0; c < 2; c++)
    begin
      ta[c] = 7'($urandom);
      td[c] = 16'($urandom);
      ram_q[c].push_back('{1'b1, ta[c], td[c]});
      frame({ctl(0, 0, 0, c), 1'b1, ta[c], td[c]}, 32, 0, 0, 0);
    end
    wait_pending(2'b11);
    serve(2'b11);
    $display("test done: table writes");
    for (int k = 0; k < 3; k++)
    begin
      for (int c = 0; c < 2; c++)
      begin
        rd = 16'($urandom);
        @(posedge i_clk);
        i_ram_rdata[c] <= rd;
        ram_q[c].push_back('{1'b0, ta[c], 16'h0});
        frame({ctl(0, 1, 0, c), 1'b0, ta[c], 16'($urandom)}, 32, 0, {16'h0, last[c]}, k > 0 ? 32'hffff : 0);
        wait_pending(2'(1 << c));
        serve(2'(1 << c));
        last[c] = rd;
      end
    end
    $display("test done: table read pipeline");
    repeat (5) @(posedge i_clk);
    check(32'(ram_q[0].size() + ram_q[1].size()), 32'h0);
    tally_and_finish();
  end
endmodule : test_daisy_chain_spi_control_port
